// *** core/sctc_core.sv ***
// single-channel 16-bit timer control core with wishbone slave
// assumes inputs synchronous to clk; debug and slave inputs come from
// neighbouring logic in the same clock domain
`timescale 1ns/1ps
`default_nettype none

module sctc_core
    import sctc_pkg::*;
(
    input wire logic clk, // timer clock, 200 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic debug_halted, // core halted in debug
    input wire logic debug_halt_pause, // pause control from debug unit
    input wire logic slave_update_event, // update from slave controller
    output logic irq, // level interrupt
    output logic ovf_dma_req, // overflow dma pulse
    output logic ch_dma_req, // channel dma pulse
    output logic sample_tick, // sample / dead-time base tick
    output logic count_down // current count direction
);

    // ************************************************************
    // state
    // ************************************************************
    sctc_ctrl_s ctrl1;
    logic [15:0] iden;
    logic [1:0] flags;
    logic [15:0] cnt;
    logic cdown;
    logic [15:0] psc_val;
    logic [15:0] psc_act;
    logic [15:0] psc_cnt;
    logic [15:0] per_val;
    logic [15:0] per_shadow;
    logic [15:0] c1dt;
    logic [1:0] dts_cnt;
    logic [2:0] div_age;
    logic [15:0] plain [SCTC_PLAIN_N];

    // merge selected byte lanes of a 16-bit register
    function automatic logic [15:0] wr16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
        wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : wr16

    // ************************************************************
    // bus decode
    // ************************************************************
    // a request is answered one cycle later; the access acts at the
    // edge where the master sees ack, so a held request acts once
    wire req = wb_cyc_i && wb_stb_i;
    wire acc = req && wb_ack_o;
    wire wr = acc && wb_we_i;
    wire rd = acc && !wb_we_i;
    wire [7:0] wadr = {wb_adr_i[7:2], 2'h0};
    wire hit_ctrl1 = (wadr == SCTC_OFS_CTRL1);
    wire hit_iden = (wadr == SCTC_OFS_IDEN);
    wire hit_ists = (wadr == SCTC_OFS_ISTS);
    wire hit_swevt = (wadr == SCTC_OFS_SWEVT);
    wire hit_cval = (wadr == SCTC_OFS_CVAL);
    wire hit_div = (wadr == SCTC_OFS_DIV);
    wire hit_pr = (wadr == SCTC_OFS_PR);
    wire hit_c1dt = (wadr == SCTC_OFS_C1DT);
    wire ctrl_wr = wr && hit_ctrl1;
    wire cnt_wr = wr && hit_cval;
    wire per_wr = wr && hit_pr;
    wire sw_trig = wr && hit_swevt && wb_sel_i[0] && wb_dat_i[SCTC_SWEVT_OVF];
    wire [15:0] ctrl_new = wr16(ctrl1, wb_dat_i, wb_sel_i) & SCTC_CTRL1_WMASK;

    // plain storage registers, one per entry
    wire [15:0] plain_or [SCTC_PLAIN_N+1];
    assign plain_or[0] = SCTC_RST16;
    genvar gi;
    generate
        for (gi = 0; gi < SCTC_PLAIN_N; gi++) begin : g_plain
            wire hit = (wadr == SCTC_PLAIN_OFS[gi]);
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    plain[gi] <= SCTC_RST16;
                end else if (wr && hit) begin
                    plain[gi] <= wr16(plain[gi], wb_dat_i, wb_sel_i);
                end
            end
            assign plain_or[gi+1] = plain_or[gi] | (hit ? plain[gi] : SCTC_RST16);
        end
    endgenerate

    // ************************************************************
    // counting control
    // ************************************************************
    // the pause only matters while debug holds the core
    wire paused = debug_halted && debug_halt_pause; // [RULE1]
    wire cnt_en = ctrl1.counter_run && !paused; // [RULE1] [RULE11]
    wire centre = (ctrl1.counting_mode_select != SCTC_MODE_ONEWAY); // [RULE5]
    wire dir_down = centre ? cdown : ctrl1.single_direction_select; // [RULE5]
    // unbuffered period takes the software value straight away
    wire [15:0] per_act = ctrl1.period_buffering_on ? per_shadow : per_val; // [RULE4]
    wire tick = cnt_en && (psc_cnt == psc_act);
    wire at_end = dir_down ? (cnt == 16'h0000) : (cnt >= per_act);
    wire hw_ovf = tick && at_end;
    // gate bit high blocks every update event, overflow or forced
    wire gate_ok = !ctrl1.overflow_event_gate; // [RULE11]
    wire forced = !ctrl1.overflow_source_select && (sw_trig || slave_update_event); // [RULE10]
    wire sw_upd = gate_ok && forced; // [RULE10]
    wire upd = gate_ok && (hw_ovf || forced); // [RULE10] [RULE11]
    // channel flag allowed per mode and direction
    wire dir_ok = (ctrl1.counting_mode_select == SCTC_MODE_ONEWAY) ||
                  (ctrl1.counting_mode_select == SCTC_MODE_BOTHFLAG) || // [RULE8]
                  ((ctrl1.counting_mode_select == SCTC_MODE_DOWNFLAG) && dir_down) || // [RULE6]
                  ((ctrl1.counting_mode_select == SCTC_MODE_UPFLAG) && !dir_down); // [RULE7]
    wire ch_hit = tick && (cnt == c1dt) && dir_ok;
    wire [1:0] flag_set = {ch_hit, upd};

    // next counter value and direction; bus write wins, then forced update
    logic [15:0] next_cnt;
    logic next_cdown;
    always_comb begin
        next_cnt = cnt;
        next_cdown = cdown;
        if (cnt_wr) begin
            next_cnt = wr16(cnt, wb_dat_i, wb_sel_i);
        end else if (sw_upd) begin
            next_cnt = (!centre && ctrl1.single_direction_select) ? per_act : 16'h0000;
            next_cdown = 1'b0;
        end else if (tick) begin
            if (dir_down) begin // [RULE5]
                if (cnt == 16'h0000) begin
                    next_cdown = 1'b0; // [RULE6] [RULE7] [RULE8]
                    next_cnt = centre ? ((per_act == 16'h0000) ? 16'h0000 : 16'h0001) : per_act;
                end else begin
                    next_cnt = cnt - 16'h0001;
                end
            end else begin
                if (cnt >= per_act) begin
                    next_cdown = centre; // [RULE6] [RULE7] [RULE8]
                    next_cnt = (centre && per_act != 16'h0000) ? per_act - 16'h0001 : 16'h0000;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end
        end
        if (!centre) begin
            next_cdown = 1'b0;
        end
    end

    // counter, direction and prescaler
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= SCTC_RST16;
            cdown <= 1'b0;
            psc_cnt <= SCTC_RST16;
            psc_act <= SCTC_RST16;
        end else begin
            cnt <= next_cnt;
            cdown <= next_cdown;
            if (tick || sw_upd) begin
                psc_cnt <= SCTC_RST16;
            end else if (cnt_en) begin
                psc_cnt <= psc_cnt + 16'h0001;
            end
            if (upd) begin
                psc_act <= psc_val;
            end
        end
    end

    // control_one; software write beats the one-cycle hardware stop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1 <= SCTC_RST16;
        end else if (ctrl_wr) begin
            ctrl1 <= ctrl_new;
        end else if (upd && ctrl1.one_cycle_stop) begin
            ctrl1.counter_run <= 1'b0; // [RULE9]
        end
    end

    // software-visible values and the period shadow
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            iden <= SCTC_RST16;
            psc_val <= SCTC_RST16;
            per_val <= SCTC_RST16;
            per_shadow <= SCTC_RST16;
            c1dt <= SCTC_RST16;
        end else begin
            if (wr && hit_iden) begin
                iden <= wr16(iden, wb_dat_i, wb_sel_i) & SCTC_IDEN_WMASK;
            end
            if (wr && hit_div) begin
                psc_val <= wr16(psc_val, wb_dat_i, wb_sel_i);
            end
            if (per_wr) begin
                per_val <= wr16(per_val, wb_dat_i, wb_sel_i);
            end
            if (upd) begin
                per_shadow <= per_val; // [RULE4]
            end
            if (wr && hit_c1dt) begin
                c1dt <= wr16(c1dt, wb_dat_i, wb_sel_i);
            end
        end
    end

    // ************************************************************
    // sample and dead-time base divider
    // ************************************************************
    // reserved setting falls back to no division rather than stalling
    wire [1:0] dts_lim = (ctrl1.sample_clock_divider == SCTC_DIV_2) ? SCTC_LIM_2 :
                         (ctrl1.sample_clock_divider == SCTC_DIV_4) ? SCTC_LIM_4 :
                         SCTC_LIM_1; // [RULE2] [RULE3]
    wire dts_wrap = (dts_cnt >= dts_lim);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dts_cnt <= 2'h0;
            sample_tick <= 1'b0;
            div_age <= 3'h0;
        end else begin
            dts_cnt <= dts_wrap ? 2'h0 : dts_cnt + 2'h1; // [RULE2]
            sample_tick <= dts_wrap; // [RULE3]
            if (ctrl_wr) begin
                div_age <= 3'h0;
            end else if (div_age != 3'h7) begin
                div_age <= div_age + 3'h1;
            end
        end
    end

    // ************************************************************
    // flags, interrupt and bus answer
    // ************************************************************
    // read clears only bits already returned, so a later set survives
    wire [1:0] flag_clr = (rd && hit_ists) ? wb_dat_o[1:0] : 2'h0;
    wire [15:0] rd16 = hit_ctrl1 ? ctrl1 :
                       hit_iden ? iden :
                       hit_ists ? {14'h0000, flags} :
                       hit_cval ? cnt :
                       hit_div ? psc_val :
                       hit_pr ? per_val :
                       hit_c1dt ? c1dt :
                       plain_or[SCTC_PLAIN_N];
    wire [1:0] irq_mask = {iden[SCTC_IRQ_CH], iden[SCTC_IRQ_OVF]};
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= 2'h0;
            irq <= 1'b0;
            ovf_dma_req <= 1'b0;
            ch_dma_req <= 1'b0;
            count_down <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set; // [RULE6] [RULE7] [RULE8]
            irq <= |(flags & irq_mask);
            ovf_dma_req <= upd && iden[SCTC_DMA_OVF];
            ch_dma_req <= ch_hit && iden[SCTC_DMA_CH];
            count_down <= dir_down;
            wb_ack_o <= req && !wb_ack_o;
            if (req && !wb_ack_o) begin
                wb_dat_o <= {16'h0000, rd16};
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_debug_freeze;
        @(posedge clk) disable iff (!arst_n)
        (paused && !cnt_wr && !sw_upd) |=> $stable(cnt);
    endproperty
    a_debug_freeze: assert property (p_debug_freeze) // [RULE1]
        else $error("counter moved while debug paused");

    property p_div_four;
        @(posedge clk) disable iff (!arst_n)
        (sample_tick && ctrl1.sample_clock_divider == SCTC_DIV_4 && div_age >= 3'h4)
        |=> !sample_tick ##1 !sample_tick ##1 !sample_tick;
    endproperty
    a_div_four: assert property (p_div_four) // [RULE2]
        else $error("divide by four spacing wrong");

    property p_div_one;
        @(posedge clk) disable iff (!arst_n)
        (ctrl1.sample_clock_divider == SCTC_DIV_1 && div_age >= 3'h2) |-> sample_tick;
    endproperty
    a_div_one: assert property (p_div_one) // [RULE3]
        else $error("undivided base tick missing");

    property p_period_held;
        @(posedge clk) disable iff (!arst_n)
        (per_wr && ctrl1.period_buffering_on && !upd) |=> $stable(per_act);
    endproperty
    a_period_held: assert property (p_period_held) // [RULE4]
        else $error("buffered period took effect early");

    property p_period_direct;
        @(posedge clk) disable iff (!arst_n)
        (per_wr && !ctrl1.period_buffering_on && wb_sel_i[1:0] == 2'h3)
        |=> per_act == $past(wb_dat_i[15:0]);
    endproperty
    a_period_direct: assert property (p_period_direct) // [RULE4]
        else $error("unbuffered period not applied");

    property p_up_step;
        @(posedge clk) disable iff (!arst_n)
        (!centre && !ctrl1.single_direction_select && tick && cnt < per_act
         && !cnt_wr && !sw_upd) |=> cnt == $past(cnt) + 16'h0001;
    endproperty
    a_up_step: assert property (p_up_step) // [RULE5]
        else $error("one-way up step wrong");

    property p_flag_down_only;
        @(posedge clk) disable iff (!arst_n)
        (ch_hit && ctrl1.counting_mode_select == SCTC_MODE_DOWNFLAG) |-> dir_down;
    endproperty
    a_flag_down_only: assert property (p_flag_down_only) // [RULE6]
        else $error("channel flag while counting up");

    property p_flag_up_only;
        @(posedge clk) disable iff (!arst_n)
        (ch_hit && ctrl1.counting_mode_select == SCTC_MODE_UPFLAG) |-> !dir_down;
    endproperty
    a_flag_up_only: assert property (p_flag_up_only) // [RULE7]
        else $error("channel flag while counting down");

    property p_flag_both;
        @(posedge clk) disable iff (!arst_n)
        (tick && cnt == c1dt && ctrl1.counting_mode_select == SCTC_MODE_BOTHFLAG)
        |=> flags[SCTC_IRQ_CH];
    endproperty
    a_flag_both: assert property (p_flag_both) // [RULE8]
        else $error("channel flag not set in mode three");

    property p_one_cycle;
        @(posedge clk) disable iff (!arst_n)
        (upd && ctrl1.one_cycle_stop && !ctrl_wr) |=> !ctrl1.counter_run;
    endproperty
    a_one_cycle: assert property (p_one_cycle) // [RULE9]
        else $error("one-cycle stop did not halt");

    property p_src_only_ovf;
        @(posedge clk) disable iff (!arst_n)
        (ctrl1.overflow_source_select && !hw_ovf) |-> !upd;
    endproperty
    a_src_only_ovf: assert property (p_src_only_ovf) // [RULE10]
        else $error("update without real overflow");

    property p_stopped;
        @(posedge clk) disable iff (!arst_n)
        (!ctrl1.counter_run && !cnt_wr && !sw_upd) |=> $stable(cnt);
    endproperty
    a_stopped: assert property (p_stopped) // [RULE11]
        else $error("counter moved while stopped");

    c_overflow: cover property (@(posedge clk) disable iff (!arst_n) hw_ovf && upd);
    c_centre_turn: cover property (@(posedge clk) disable iff (!arst_n)
        centre && $rose(cdown));
    c_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));
    c_sw_update: cover property (@(posedge clk) disable iff (!arst_n) sw_upd);

endmodule : sctc_core

`default_nettype wire

// *** core/sctc_pkg.sv ***
// constants, field layouts and carriers of the timer control core
// assumes one timer clock and a classic wishbone register port
//
// What this block does
// [RULE1] counter freezes while core is debug-halted and the pause control is set
// [RULE2] divider field 00/01/10 gives sample clock of clock, /2, /4; 11 reserved
// [RULE3] same divider setting fixes the dead-time base period ratio
// [RULE4] period buffering on holds a new period until update; off acts at once
// [RULE5] mode 00 counts one way; direction bit 0 counts up, 1 counts down
// [RULE6] mode 01 counts up and down; channel flag set only while counting down
// [RULE7] mode 10 counts up and down; channel flag set only while counting up
// [RULE8] mode 11 counts up and down; channel flag set in both directions
// [RULE9] one-cycle stop bit halts counting at the next update event
// [RULE10] overflow source bit 1 admits only real overflow as update source
// [RULE11] overflow event gate and counter run bits gate events and counting
package sctc_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] SCTC_OFS_CTRL1 = 8'h00;
    localparam logic [7:0] SCTC_OFS_IDEN = 8'h0C;
    localparam logic [7:0] SCTC_OFS_ISTS = 8'h10;
    localparam logic [7:0] SCTC_OFS_SWEVT = 8'h14;
    localparam logic [7:0] SCTC_OFS_CVAL = 8'h24;
    localparam logic [7:0] SCTC_OFS_DIV = 8'h28;
    localparam logic [7:0] SCTC_OFS_PR = 8'h2C;
    localparam logic [7:0] SCTC_OFS_C1DT = 8'h34;
    // plain storage: ctrl2, mode, output ctrl, repetition, break, burst ctrl/data
    localparam int SCTC_PLAIN_N = 7;
    localparam logic [7:0] SCTC_PLAIN_OFS [SCTC_PLAIN_N] =
        '{8'h04, 8'h18, 8'h20, 8'h30, 8'h44, 8'h48, 8'h4C};

    // ************************************************************
    // reset values, write masks and field positions
    // ************************************************************
    localparam logic [15:0] SCTC_RST16 = 16'h0000;
    localparam logic [15:0] SCTC_CTRL1_WMASK = 16'h03FF;
    localparam logic [15:0] SCTC_IDEN_WMASK = 16'h0303;
    localparam int SCTC_IRQ_OVF = 0;
    localparam int SCTC_IRQ_CH = 1;
    localparam int SCTC_DMA_OVF = 8;
    localparam int SCTC_DMA_CH = 9;
    localparam int SCTC_SWEVT_OVF = 0;

    // ************************************************************
    // counting modes and sample divider settings
    // ************************************************************
    localparam logic [1:0] SCTC_MODE_ONEWAY = 2'h0;
    localparam logic [1:0] SCTC_MODE_DOWNFLAG = 2'h1;
    localparam logic [1:0] SCTC_MODE_UPFLAG = 2'h2;
    localparam logic [1:0] SCTC_MODE_BOTHFLAG = 2'h3;
    localparam logic [1:0] SCTC_DIV_1 = 2'h0;
    localparam logic [1:0] SCTC_DIV_2 = 2'h1;
    localparam logic [1:0] SCTC_DIV_4 = 2'h2;
    localparam logic [1:0] SCTC_LIM_1 = 2'h0;
    localparam logic [1:0] SCTC_LIM_2 = 2'h1;
    localparam logic [1:0] SCTC_LIM_4 = 2'h3;

    // control_one layout
    typedef struct packed {
        logic [5:0] rsvd;
        logic [1:0] sample_clock_divider;
        logic period_buffering_on;
        logic [1:0] counting_mode_select;
        logic single_direction_select;
        logic one_cycle_stop;
        logic overflow_source_select;
        logic overflow_event_gate;
        logic counter_run;
    } sctc_ctrl_s;

endpackage : sctc_pkg

// *** dv/tb_sctc_core.sv ***
// testbench for the timer control core: register bus, counting, events
// assumes a one-cycle wishbone ack and read-clear interrupt flags
`timescale 1ns/1ps
`default_nettype none

module tb_sctc_core;
    import sctc_pkg::*;

    // ****************************************
    // signals and design instance
    // ****************************************
    logic clk, arst_n, cyc, stb, we, halt, pause, slv;
    logic [7:0] adr;
    logic [31:0] wdat, rdat;
    logic ack, irq, ovf_dma, ch_dma, tick, cdn;
    logic [15:0] q;
    int mismatches, samples_checked, ticks, dmas, chdmas, t0;
    logic [7:0] offs [15] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24,
        8'h28, 8'h2C, 8'h30, 8'h34, 8'h44, 8'h48, 8'h4C};

    sctc_core sctc_core_i (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .debug_halted(halt), .debug_halt_pause(pause),
        .slave_update_event(slv), .irq(irq), .ovf_dma_req(ovf_dma), .ch_dma_req(ch_dma),
        .sample_tick(tick), .count_down(cdn));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // pulses are counted on the falling edge, where they are settled
    always @(negedge clk) begin
        if (tick === 1'b1) ticks++;
        if (ovf_dma === 1'b1) dmas++;
        if (ch_dma === 1'b1) chdmas++;
    end

    // ****************************************
    // bus and checking tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; held until ack is sampled, then one idle cycle follows
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 64);
        q = rdat[15:0];
        if (n >= 64) chk(16'h0000, 16'hFFFF);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        xfer(1'b0, a, 16'h0000);
        chk(q & m, e);
    endtask : rdc

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        summarize();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        {arst_n, cyc, stb, we, halt, pause, slv, adr, wdat} = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        // reset values, unmapped place and read-only bits
        foreach (offs[i]) rdc(offs[i], 16'hFFFF, 16'h0000);
        wr(8'h08, 16'h1234);
        rdc(8'h08, 16'hFFFF, 16'h0000);
        wr(8'h18, 16'hA5C3);
        rdc(8'h18, 16'hFFFF, 16'hA5C3);
        wr(SCTC_OFS_CTRL1, 16'hFFFF);
        rdc(SCTC_OFS_CTRL1, 16'hFFFF, 16'h03FF);
        // sample tick rate for every divider code; 11 behaves as 00
        for (int d = 0; d < 4; d++) begin
            wr(SCTC_OFS_CTRL1, 16'(d << 8));
            repeat (4) @(posedge clk);
            t0 = ticks;
            repeat (16) @(posedge clk);
            chk(16'(ticks - t0), (d == 1) ? 16'h0008 : (d == 2) ? 16'h0004 : 16'h0010);
        end
        // software trigger raises irq and dma, read clears flag
        wr(SCTC_OFS_CTRL1, 16'h0000);
        rdc(SCTC_OFS_ISTS, 16'h0000, 16'h0000);
        wr(SCTC_OFS_IDEN, 16'h0101);
        t0 = dmas;
        wr(SCTC_OFS_SWEVT, 16'h0001);
        repeat (3) @(posedge clk);
        chk({15'h0, irq}, 16'h0001);
        chk(16'(dmas - t0), 16'h0001);
        rdc(SCTC_OFS_ISTS, 16'h0001, 16'h0001);
        repeat (3) @(posedge clk);
        chk({15'h0, irq}, 16'h0000);
        wr(SCTC_OFS_IDEN, 16'h0000);
        @(posedge clk) slv <= 1'b1;
        @(posedge clk) slv <= 1'b0;
        repeat (3) @(posedge clk);
        chk({15'h0, irq}, 16'h0000);
        rdc(SCTC_OFS_ISTS, 16'h0001, 16'h0001);
        // source limited to real overflow, then gate closed
        for (int k = 0; k < 2; k++) begin
            wr(SCTC_OFS_CTRL1, k ? 16'h0002 : 16'h0004);
            wr(SCTC_OFS_SWEVT, 16'h0001);
            @(posedge clk) slv <= 1'b1;
            @(posedge clk) slv <= 1'b0;
            rdc(SCTC_OFS_ISTS, 16'h0001, 16'h0000);
        end
        // real overflow in one-way up counting
        wr(SCTC_OFS_CTRL1, 16'h0000);
        wr(SCTC_OFS_PR, 16'h0005);
        wr(SCTC_OFS_CTRL1, 16'h0001);
        repeat (20) @(posedge clk);
        rdc(SCTC_OFS_ISTS, 16'h0001, 16'h0001);
        // debug halt freezes only with the pause control set
        wr(SCTC_OFS_CTRL1, 16'h0000);
        halt <= 1'b1;
        pause <= 1'b1;
        wr(SCTC_OFS_PR, 16'hFFFF);
        wr(SCTC_OFS_CVAL, 16'h0010);
        wr(SCTC_OFS_CTRL1, 16'h0001);
        repeat (20) @(posedge clk);
        rdc(SCTC_OFS_CVAL, 16'hFFFF, 16'h0010);
        pause <= 1'b0;
        repeat (10) @(posedge clk);
        xfer(1'b0, SCTC_OFS_CVAL, 16'h0000);
        chk({15'h0, q > 16'h0010}, 16'h0001);
        halt <= 1'b0;
        // one-way down counting
        wr(SCTC_OFS_CTRL1, 16'h0000);
        wr(SCTC_OFS_CVAL, 16'h0100);
        wr(SCTC_OFS_CTRL1, 16'h0011);
        repeat (20) @(posedge clk);
        chk({15'h0, cdn}, 16'h0001);
        xfer(1'b0, SCTC_OFS_CVAL, 16'h0000);
        chk({15'h0, q < 16'h0100}, 16'h0001);
        // one-cycle stop clears the run bit at the update event
        wr(SCTC_OFS_CTRL1, 16'h0000);
        wr(SCTC_OFS_PR, 16'h0003);
        wr(SCTC_OFS_CVAL, 16'h0000);
        wr(SCTC_OFS_CTRL1, 16'h0009);
        repeat (40) @(posedge clk);
        rdc(SCTC_OFS_CTRL1, 16'h0001, 16'h0000);
        // buffered period waits for an update, unbuffered acts at once
        wr(SCTC_OFS_PR, 16'hFFFF);
        wr(SCTC_OFS_SWEVT, 16'h0001);
        wr(SCTC_OFS_CTRL1, 16'h0080);
        wr(SCTC_OFS_PR, 16'h0004);
        wr(SCTC_OFS_CVAL, 16'h0010);
        wr(SCTC_OFS_CTRL1, 16'h0081);
        repeat (20) @(posedge clk);
        xfer(1'b0, SCTC_OFS_CVAL, 16'h0000);
        chk({15'h0, q > 16'h0004}, 16'h0001);
        wr(SCTC_OFS_CTRL1, 16'h0001);
        wr(SCTC_OFS_PR, 16'h0004);
        repeat (20) @(posedge clk);
        xfer(1'b0, SCTC_OFS_CVAL, 16'h0000);
        chk({15'h0, q <= 16'h0004}, 16'h0001);
        // channel match on the way up: every mode but 01 flags it and asks for dma
        wr(SCTC_OFS_IDEN, 16'h0200);
        for (int m = 0; m < 4; m++) begin
            wr(SCTC_OFS_CTRL1, 16'h0000);
            rdc(SCTC_OFS_ISTS, 16'h0000, 16'h0000);
            t0 = chdmas;
            wr(SCTC_OFS_C1DT, 16'h0003);
            wr(SCTC_OFS_PR, 16'h0040);
            wr(SCTC_OFS_CVAL, 16'h0000);
            wr(SCTC_OFS_CTRL1, 16'((m << 5) | 1));
            repeat (20) @(posedge clk);
            wr(SCTC_OFS_CTRL1, 16'h0000);
            rdc(SCTC_OFS_ISTS, 16'h0002, (m == 1) ? 16'h0000 : 16'h0002);
            chk(16'(chdmas - t0), (m == 1) ? 16'h0000 : 16'h0001);
        end
        summarize();
    end

endmodule : tb_sctc_core

`default_nettype wire
